// ===== dio_pkg.sv
// constants, field layout and mode codes for the digital i/o channel block
package dio_pkg;
    localparam int CLK_NS      = 10;
    localparam int TICK_NS     = 100000;
    localparam int TICK_CYC    = TICK_NS / CLK_NS;
    localparam int TICKS_PER_S = 1000000000 / TICK_NS;
    localparam int LOCATE_S    = 30;
    localparam int LOCATE_TICK = LOCATE_S * TICKS_PER_S;
    localparam int GATE_S      = 1;
    localparam int GATE_TICK   = GATE_S * TICKS_PER_S;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_WIDTH  = 8'h08;
    localparam logic [7:0] OFS_TOTAL  = 8'h0C;
    localparam logic [7:0] OFS_DELAY  = 8'h10;
    localparam logic [7:0] OFS_IDLE   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_FREQ   = 8'h1C;
    localparam logic [7:0] OFS_PERIOD = 8'h20;

    // control register fields
    localparam int CTL_IMODE   = 0;
    localparam int CTL_INV     = 2;
    localparam int CTL_OMODE   = 4;
    localparam int CTL_OCMD    = 6;
    localparam int CTL_FS_EN   = 7;
    localparam int CTL_PEER_EN = 8;
    localparam int CTL_CONT    = 9;
    localparam int CTL_HWD_EN  = 10;
    localparam int CTL_PWD_EN  = 11;
    localparam int CTL_W       = 12;
    localparam logic [CTL_W-1:0] CTL_RST = 12'h000;
    // command register bits, write one to act
    localparam int CMD_CLR    = 0;
    localparam int CMD_START  = 1;
    localparam int CMD_STOP   = 2;
    localparam int CMD_LOCATE = 3;
    localparam logic [31:0] WIDTH_RST = 32'h0001_0001;
    localparam logic [15:0] TOTAL_RST = 16'h0001;
    localparam logic [15:0] DELAY_RST = 16'h0001;
    localparam logic [31:0] IDLE_RST  = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {
        IN_PLAIN = 2'h0,
        IN_RISE  = 2'h1,
        IN_FALL  = 2'h2,
        IN_FREQ  = 2'h3
    } in_mode_t;

    typedef enum logic [1:0] {
        OUT_PLAIN = 2'h0,
        OUT_PULSE = 2'h1,
        OUT_DRISE = 2'h2,
        OUT_DFALL = 2'h3
    } out_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HI   = 4'h2,
        ST_LO   = 4'h4,
        ST_DLY  = 4'h8
    } out_state_t;
endpackage

// ===== dio_in_chan.sv
// input channel: inversion, edge latches and frequency gate
`timescale 1ns/100ps
module dio_in_chan #(
    parameter int GATE_TICKS = dio_pkg::GATE_TICK
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             din,
    input  wire logic             invert,
    input  wire dio_pkg::in_mode_t mode,
    input  wire logic             clr,
    input  wire logic             tick,
    output logic                  level_r,
    output logic                  latch_r,
    output logic [31:0]           freq_r
);
    logic        din_r;
    logic        prev_r;
    logic [31:0] edge_cnt_r;
    logic [31:0] gate_cnt_r;
    wire         rise     = level_r & ~prev_r;
    wire         fall     = ~level_r & prev_r;
    wire         set_rise = (mode == dio_pkg::IN_RISE) & rise;
    wire         set_fall = (mode == dio_pkg::IN_FALL) & fall;
    wire         set      = set_rise | set_fall;
    wire         gate_end = tick & (gate_cnt_r == 32'(GATE_TICKS - 1));
    wire         fmode    = (mode == dio_pkg::IN_FREQ);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            din_r   <= 1'b0;
            level_r <= 1'b0;
            prev_r  <= 1'b0;
            latch_r <= 1'b0;
        end
        else
        begin
            din_r   <= din;
            level_r <= din_r ^ invert;
            prev_r  <= level_r;
            latch_r <= set | (latch_r & ~clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            edge_cnt_r <= 32'h0000_0000;
            gate_cnt_r <= 32'h0000_0000;
            freq_r     <= 32'h0000_0000;
        end
        else if (!fmode)
        begin
            edge_cnt_r <= 32'h0000_0000;
            gate_cnt_r <= 32'h0000_0000;
        end
        else if (gate_end)
        begin
            freq_r     <= edge_cnt_r + 32'(rise);
            edge_cnt_r <= 32'h0000_0000;
            gate_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            edge_cnt_r <= edge_cnt_r + 32'(rise);
            gate_cnt_r <= gate_cnt_r + 32'(tick);
        end
    end

    rise_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_rise |=> latch_r) else $error("rising edge not latched");
    fall_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == dio_pkg::IN_FALL && prev_r && !level_r) |=> latch_r)
        else $error("falling edge not latched");
    latch_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (latch_r && clr && !set) |=> !latch_r ##1 (latch_r == $past(set)))
        else $error("latch clear or rearm wrong");
    inv_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (invert && !din_r) |=> level_r) else $error("inverted idle not high");
endmodule // dio_in_chan

// ===== dio_out_chan.sv
// output channel: plain, pulse train and delayed transitions
`timescale 1ns/100ps
module dio_out_chan (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire dio_pkg::out_mode_t mode,
    input  wire logic              cmd,
    input  wire logic              cont,
    input  wire logic              start,
    input  wire logic              stop,
    input  wire logic [15:0]       low_w,
    input  wire logic [15:0]       high_w,
    input  wire logic [15:0]       total,
    input  wire logic [15:0]       delay,
    input  wire logic              tick,
    output logic                   out_r,
    output logic                   busy_r
);
    dio_pkg::out_state_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] left_r, left_nxt;
    logic        out_nxt;
    wire         pmode   = (mode == dio_pkg::OUT_PULSE);
    wire         dly_dir = (mode == dio_pkg::OUT_DRISE);
    wire         expire  = tick & (cnt_r <= 16'h0001);

    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        left_nxt = left_r;
        out_nxt  = out_r;
        case (st_r)
            dio_pkg::ST_HI, dio_pkg::ST_LO:
            begin
                if (!pmode || stop)
                begin
                    st_nxt  = dio_pkg::ST_IDLE;
                    out_nxt = 1'b0;
                end
                else if (expire && st_r == dio_pkg::ST_HI)
                begin
                    st_nxt  = dio_pkg::ST_LO;
                    cnt_nxt = low_w;
                    out_nxt = 1'b0;
                end
                else if (expire && !cont && left_r <= 16'h0001)
                    st_nxt = dio_pkg::ST_IDLE;
                else if (expire)
                begin
                    st_nxt   = dio_pkg::ST_HI;
                    cnt_nxt  = high_w;
                    left_nxt = left_r - 16'h0001;
                    out_nxt  = 1'b1;
                end
                else
                    cnt_nxt = cnt_r - 16'(tick);
            end
            dio_pkg::ST_DLY:
            begin
                if (pmode || mode == dio_pkg::OUT_PLAIN || cmd != dly_dir)
                    st_nxt = dio_pkg::ST_IDLE;
                else if (expire)
                begin
                    st_nxt  = dio_pkg::ST_IDLE;
                    out_nxt = cmd;
                end
                else
                    cnt_nxt = cnt_r - 16'(tick);
            end
            default:
            begin
                if (pmode)
                begin
                    out_nxt = 1'b0;
                    if (start)
                    begin
                        st_nxt   = dio_pkg::ST_HI;
                        cnt_nxt  = high_w;
                        left_nxt = total;
                        out_nxt  = 1'b1;
                    end
                end
                else if (mode == dio_pkg::OUT_PLAIN)
                    out_nxt = cmd;
                else if (cmd != out_r && cmd == dly_dir)
                begin
                    st_nxt  = dio_pkg::ST_DLY;
                    cnt_nxt = delay;
                end
                else
                    out_nxt = cmd;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r   <= dio_pkg::ST_IDLE;
            cnt_r  <= 16'h0000;
            left_r <= 16'h0000;
            out_r  <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            left_r <= left_nxt;
            out_r  <= out_nxt;
            busy_r <= (st_nxt == dio_pkg::ST_HI) | (st_nxt == dio_pkg::ST_LO);
        end
    end

    plain_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == dio_pkg::OUT_PLAIN && st_r == dio_pkg::ST_IDLE) |=> out_r == $past(cmd))
        else $error("plain output not following command");
    rise_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == dio_pkg::ST_DLY && mode == dio_pkg::OUT_DRISE) |-> !out_r)
        else $error("delayed rise output went high early");
    fall_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == dio_pkg::ST_DLY && mode == dio_pkg::OUT_DFALL) |-> out_r)
        else $error("delayed fall output went low early");
    pulse_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy_r && stop) |=> !busy_r && !out_r) else $error("pulse stop ignored");
endmodule // dio_out_chan

// ===== dio_channel.sv
// top: apb registers, tick base, watchdogs, locate led and one channel pair
`timescale 1ns/100ps
module dio_channel #(
    parameter int TICK_CYC    = dio_pkg::TICK_CYC,
    parameter int LOCATE_TICK = dio_pkg::LOCATE_TICK,
    parameter int GATE_TICK   = dio_pkg::GATE_TICK
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        din,
    input  wire logic        host_pkt,
    input  wire logic        peer_pkt,
    output logic             dout,
    output logic             led,
    output logic             peer_safe_report
);
    logic [dio_pkg::CTL_W-1:0] ctrl_r;
    logic [31:0] width_r;
    logic [15:0] total_r;
    logic [15:0] delay_r;
    logic [31:0] idle_r;
    logic        clr_r;
    logic        start_r;
    logic        stop_r;
    logic [31:0] tick_cnt_r;
    logic        tick_r;
    logic [15:0] host_cnt_r;
    logic [15:0] peer_cnt_r;
    logic        host_to_r;
    logic        peer_to_r;
    logic [31:0] loc_cnt_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        dout_r;
    logic        led_r;
    logic        peer_rep_r;
    logic        in_level;
    logic        in_latch;
    logic [31:0] in_freq;
    logic        ch_out;
    logic        ch_busy;
    logic [31:0] rdata;
    logic        hit;

    // idle timer: saturating tick count since last packet
    function automatic logic [15:0] idle_step(input logic [15:0] cnt,
                                              input logic pkt,
                                              input logic tk);
        if (pkt)
            idle_step = 16'h0000;
        else if (tk && cnt != 16'hFFFF)
            idle_step = cnt + 16'h0001;
        else
            idle_step = cnt;
    endfunction

    wire        setup    = psel & ~penable;
    wire        access   = psel & penable & ~pready_r;
    wire        done     = psel & penable & pready_r;
    wire        wr       = done & pwrite & hit;
    wire        wr_ctrl  = wr & (paddr == dio_pkg::OFS_CTRL);
    wire        wr_cmd   = wr & (paddr == dio_pkg::OFS_CMD);
    wire        wr_width = wr & (paddr == dio_pkg::OFS_WIDTH);
    wire        wr_total = wr & (paddr == dio_pkg::OFS_TOTAL);
    wire        wr_delay = wr & (paddr == dio_pkg::OFS_DELAY);
    wire        wr_idle  = wr & (paddr == dio_pkg::OFS_IDLE);
    wire [15:0] low_w    = width_r[15:0];
    wire [15:0] high_w   = width_r[31:16];
    wire [16:0] period   = {1'b0, low_w} + {1'b0, high_w};
    // a packet restarts the idle count, so it must also beat the stale expiry of that cycle
    wire        host_exp = ctrl_r[dio_pkg::CTL_HWD_EN] & ~host_pkt & (host_cnt_r > idle_r[15:0]);
    wire        peer_exp = ctrl_r[dio_pkg::CTL_PWD_EN] & ~peer_pkt & (peer_cnt_r > idle_r[31:16]);
    wire        fs_force = ctrl_r[dio_pkg::CTL_FS_EN] & host_to_r;
    wire [7:0]  status   = {led_r, peer_rep_r, peer_to_r, host_to_r,
                            ch_busy, dout_r, in_level, in_latch};
    wire        tick_end = (tick_cnt_r == 32'(TICK_CYC - 1));

    always_comb
    begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        if (paddr == dio_pkg::OFS_CTRL)
            rdata = {20'h0_0000, ctrl_r};
        else if (paddr == dio_pkg::OFS_CMD)
            rdata = 32'h0000_0000;
        else if (paddr == dio_pkg::OFS_WIDTH)
            rdata = width_r;
        else if (paddr == dio_pkg::OFS_TOTAL)
            rdata = {16'h0000, total_r};
        else if (paddr == dio_pkg::OFS_DELAY)
            rdata = {16'h0000, delay_r};
        else if (paddr == dio_pkg::OFS_IDLE)
            rdata = idle_r;
        else if (paddr == dio_pkg::OFS_STATUS)
            rdata = {24'h00_0000, status};
        else if (paddr == dio_pkg::OFS_FREQ)
            rdata = in_freq;
        else if (paddr == dio_pkg::OFS_PERIOD)
            rdata = {15'h0000, period};
        else
            hit = 1'b0;
    end

    // apb slave: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= access;
            pslverr_r <= access & ~hit;
            prdata_r  <= (access & ~pwrite) ? rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r  <= dio_pkg::CTL_RST;
            width_r <= dio_pkg::WIDTH_RST;
            total_r <= dio_pkg::TOTAL_RST;
            delay_r <= dio_pkg::DELAY_RST;
            idle_r  <= dio_pkg::IDLE_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= pwdata[dio_pkg::CTL_W-1:0];
            if (wr_width)
                width_r <= pwdata;
            if (wr_total)
                total_r <= pwdata[15:0];
            if (wr_delay)
                delay_r <= pwdata[15:0];
            if (wr_idle)
                idle_r <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clr_r   <= 1'b0;
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end
        else
        begin
            clr_r   <= wr_cmd & pwdata[dio_pkg::CMD_CLR];
            start_r <= wr_cmd & pwdata[dio_pkg::CMD_START];
            stop_r  <= wr_cmd & pwdata[dio_pkg::CMD_STOP];
        end
    end

    // 0.1 ms time base
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
        end
        else
        begin
            tick_cnt_r <= tick_end ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
            tick_r     <= tick_end;
        end
    end

    // watchdogs: timeout is set on expiry, ended by the next packet
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_cnt_r <= 16'h0000;
            peer_cnt_r <= 16'h0000;
            host_to_r  <= 1'b0;
            peer_to_r  <= 1'b0;
            peer_rep_r <= 1'b0;
        end
        else
        begin
            host_cnt_r <= idle_step(host_cnt_r, host_pkt, tick_r);
            peer_cnt_r <= idle_step(peer_cnt_r, peer_pkt, tick_r);
            host_to_r  <= host_exp | (host_to_r & ~host_pkt);
            peer_to_r  <= peer_exp | (peer_to_r & ~peer_pkt);
            peer_rep_r <= (peer_exp | (peer_to_r & ~peer_pkt))
                          & ctrl_r[dio_pkg::CTL_PEER_EN];
        end
    end

    // locate timer and pin outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            loc_cnt_r <= 32'h0000_0000;
            led_r     <= 1'b0;
            dout_r    <= 1'b0;
        end
        else
        begin
            if (wr_cmd && pwdata[dio_pkg::CMD_LOCATE])
                loc_cnt_r <= 32'(LOCATE_TICK);
            else if (tick_r && loc_cnt_r != 32'h0000_0000)
                loc_cnt_r <= loc_cnt_r - 32'h0000_0001;
            led_r  <= (loc_cnt_r != 32'h0000_0000);
            dout_r <= fs_force | ch_out;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign dout             = dout_r;
    assign led              = led_r;
    assign peer_safe_report = peer_rep_r;

    dio_in_chan #(
        .GATE_TICKS (GATE_TICK)
    ) u_in (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (din),
        .invert  (ctrl_r[dio_pkg::CTL_INV]),
        .mode    (dio_pkg::in_mode_t'(ctrl_r[dio_pkg::CTL_IMODE +: 2])),
        .clr     (clr_r),
        .tick    (tick_r),
        .level_r (in_level),
        .latch_r (in_latch),
        .freq_r  (in_freq)
    );

    dio_out_chan u_out (
        .pclk    (pclk),
        .presetn (presetn),
        .mode    (dio_pkg::out_mode_t'(ctrl_r[dio_pkg::CTL_OMODE +: 2])),
        .cmd     (ctrl_r[dio_pkg::CTL_OCMD]),
        .cont    (ctrl_r[dio_pkg::CTL_CONT]),
        .start   (start_r),
        .stop    (stop_r),
        .low_w   (low_w),
        .high_w  (high_w),
        .total   (total_r),
        .delay   (delay_r),
        .tick    (tick_r),
        .out_r   (ch_out),
        .busy_r  (ch_busy)
    );

    fs_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        fs_force |=> dout_r) else $error("fail-safe output not high");
    host_to_a: assert property (@(posedge pclk) disable iff (!presetn)
        (host_exp && !host_to_r) |=> host_to_r) else $error("host watchdog missed");
    host_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
        (host_pkt && !host_exp) |=> !host_to_r ##0 host_cnt_r == 16'h0000)
        else $error("host packet did not end timeout");
    led_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && pwdata[dio_pkg::CMD_LOCATE]) |=> ##1 led_r)
        else $error("locate did not light led");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup ##1 (psel && penable)) |-> !pready_r ##1 pready_r)
        else $error("apb answer not after one wait");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready_r |=> !pready_r)
        else $error("apb ready held longer than one cycle");
    slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr_r |-> pready_r)
        else $error("apb error without ready");
    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready_r |-> prdata_r == 32'h0000_0000)
        else $error("read data not zero outside answer");
    ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_ctrl |=> $stable(ctrl_r))
        else $error("control changed without a write");
    cmd_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_r || start_r || stop_r) |=> !(clr_r || start_r || stop_r))
        else $error("command strobe longer than one cycle");
    peer_report_a: assert property (@(posedge pclk) disable iff (!presetn)
        (peer_exp && ctrl_r[dio_pkg::CTL_PEER_EN]) |=> peer_rep_r)
        else $error("peer timeout not reported");
    peer_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r[dio_pkg::CTL_PEER_EN] |=> !peer_rep_r)
        else $error("peer report while disabled");
    led_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (loc_cnt_r == 32'h0000_0000) |=> !led_r)
        else $error("locate led on after timer ran out");
endmodule // dio_channel

// ===== dio_field_model.sv
// far-side model: field input source and network packet pulses
`timescale 1ns/100ps
module dio_field_model (
    input  wire logic pclk,
    input  wire logic lvl,
    input  wire logic pkt_go,
    output logic      din,
    output logic      host_pkt,
    output logic      peer_pkt
);
    initial
    begin
        din      = 1'b0;
        host_pkt = 1'b0;
        peer_pkt = 1'b0;
    end
    // field level and packet pulses move only just after a clock edge
    always @(posedge pclk)
    begin
        din      <= lvl;
        host_pkt <= pkt_go;
        peer_pkt <= pkt_go;
    end
endmodule // dio_field_model

// ===== digital_io_channel_modes_test.sv
// self-checking bench for the digital i/o channel block
`timescale 1ns/100ps
module digital_io_channel_modes_test;
    logic        pclk, presetn, psel, penable, pwrite, lvl, pkt_go, serr, pd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, v;
    logic        pready, pslverr, din, host_pkt, peer_pkt, dout, led, rpt;
    int          n_fail = 0, compares = 0, seed = 2268, k, ed;
    dio_channel #(.TICK_CYC(4), .LOCATE_TICK(20), .GATE_TICK(10)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .din(din), .host_pkt(host_pkt), .peer_pkt(peer_pkt),
        .dout(dout), .led(led), .peer_safe_report(rpt));
    dio_field_model u_far (.pclk(pclk), .lvl(lvl), .pkt_go(pkt_go), .din(din), .host_pkt(host_pkt),
        .peer_pkt(peer_pkt));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic give_verdict;
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // read after a settling pause, compare the masked word
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        cyc(6);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, lvl, pkt_go} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(5);
        presetn <= 1'b1;
        rdc(8'h08, 32'hFFFFFFFF, 32'h00010001);
        rdc(8'h14, 32'hFFFFFFFF, 32'hFFFFFFFF);
        rdc(8'h24, 32'hFFFFFFFF, 32'h0);
        chk(serr, 1'b1);
        wr(8'h00, 32'h1);
        lvl <= 1'b1;
        cyc(6);
        lvl <= 1'b0;
        rdc(8'h18, 32'h1, 32'h1);
        wr(8'h04, 32'h1);
        rdc(8'h18, 32'h1, 32'h0);
        lvl <= 1'b1;
        rdc(8'h18, 32'h1, 32'h1);
        lvl <= 1'b0;
        wr(8'h00, 32'h6);
        wr(8'h04, 32'h1);
        rdc(8'h18, 32'h3, 32'h2);
        lvl <= 1'b1;
        rdc(8'h18, 32'h1, 32'h1);
        wr(8'h00, 32'h3);
        fork
            repeat (40)
            begin
                cyc(4);
                lvl <= ~lvl;
            end
        join_none
        cyc(100);
        rdc(8'h1C, 32'hFFFFFFFF, 32'h5);
        cyc(70);
        for (k = 0; k < 4; k++)
        begin
            v = $random(seed);
            wr(8'h00, {25'h0, v[0], 6'h0});
            rdc(8'h18, 32'h4, {29'h0, v[0], 2'h0});
            chk(dout, v[0]);
        end
        wr(8'h08, 32'h00020003);
        rdc(8'h20, 32'hFFFFFFFF, 32'h5);
        wr(8'h0C, 32'h3);
        wr(8'h00, 32'h10);
        wr(8'h04, 32'h2);
        ed = 0;
        repeat (150)
        begin
            pd = dout;
            @(posedge pclk);
            ed += int'(!dout && pd);
        end
        chk(ed, 3);
        wr(8'h00, 32'h210);
        wr(8'h04, 32'h2);
        cyc(30);
        wr(8'h04, 32'h4);
        rdc(8'h18, 32'hC, 32'h0);
        wr(8'h10, 32'h5);
        for (k = 2; k < 4; k++)
        begin
            wr(8'h00, (k << 4) | ((k - 2) << 6));
            cyc(30);
            wr(8'h00, (k << 4) | ((3 - k) << 6));
            cyc(8);
            chk(dout, k - 2);
            cyc(20);
            chk(dout, 3 - k);
        end
        wr(8'h04, 32'h8);
        cyc(3);
        chk(led, 1'b1);
        cyc(90);
        chk(led, 1'b0);
        wr(8'h14, 32'h00030003);
        wr(8'h00, 32'hD80);
        cyc(40);
        chk(dout, 1'b1);
        chk(rpt, 1'b1);
        pkt_go <= 1'b1;
        cyc(1);
        pkt_go <= 1'b0;
        cyc(4);
        chk(dout, 1'b0);
        give_verdict();
    end
endmodule // digital_io_channel_modes_test
